// File: src/gcr_pkg.sv
// Constants, types and helpers shared by the gauge command and homing logic.
//------------------------------------------------------------------------------
// Function
// - Gauge0 apply bit set adopts velocity index
// - Velocity index 1..255 held until replaced
// - Addresses 010/011 load 12-bit target positions
// - Homing uses full steps, integrates back-EMF
// - Address 100 D1 enables, D0 picks gauge
// - D3:D2 pick accumulator readback window bits
// - Window changes allowed during homing motion
// - Readback is previous step; first all ones
// - D4 chooses automatic or unconditional stopping
// - Config D3:D0 sets full step time
// - Blanking 512 or 768 us per step
// - Sign zero continues, sign one stalls
// - Window 1x shows sign on status 14
// - Accumulator reinitialised every full step
// - Config D12:D5 sets negative accumulator preload
// - Reset preload gives minus one
// - Preload equals minus sixteen code minus one
// - Step times 4.86 to 62.21 ms
// - Homing flag holds until next message
// - Latch only on whole 16-bit multiples
//------------------------------------------------------------------------------
package gcr_pkg;

   // Command addresses carried in the top three bits of a word.
   localparam logic [2:0] ADR_VEL  = 3'h1;
   localparam logic [2:0] ADR_POS0 = 3'h2;
   localparam logic [2:0] ADR_POS1 = 3'h3;
   localparam logic [2:0] ADR_RTZ  = 3'h4;
   localparam logic [2:0] ADR_CFG  = 3'h5;

   // Reset values of the configuration state, first readback and accumulator limits.
   localparam logic [3:0]  STEP_CODE_RST = 4'h5;
   localparam logic        BLANK_SEL_RST = 1'b0;
   localparam logic [7:0]  PRELOAD_RST   = 8'h00;
   localparam logic [7:0]  VEL_RST       = 8'hff;
   localparam logic [11:0] POS_RST       = 12'h000;
   localparam logic [14:0] ACC_FIRST     = 15'h7fff;
   localparam logic [14:0] ACC_ZERO      = 15'h0000;
   localparam logic [14:0] ACC_MAX       = 15'h3fff;
   localparam logic [14:0] ACC_MIN       = 15'h4000;

   // Timing: 20 ns clock, so 50 cycles per microsecond.
   localparam int unsigned CLK_PERIOD_NS  = 20;
   localparam int unsigned CYC_PER_US     = 1000 / CLK_PERIOD_NS;
   localparam int unsigned BLANK_SHORT_US = 512;
   localparam int unsigned BLANK_LONG_US  = 768;

   // Full step times in units of 10 us, 4.86 ms up to 62.21 ms.
   localparam logic [12:0] STEP_TIME_10US [16] = '{
      13'd486, 13'd486, 13'd896, 13'd1306, 13'd1715, 13'd2125, 13'd2534, 13'd2944,
      13'd3354, 13'd3763, 13'd4173, 13'd4582, 13'd4992, 13'd5402, 13'd5811, 13'd6221};

   // One latched command word.
   typedef struct packed {
      logic [2:0]  addr;
      logic [12:0] data;
   } gcr_cmd_t;

   // Homing engine states.
   typedef enum logic [1:0] {
      GCR_IDLE  = 2'b00,
      GCR_BLANK = 2'b01,
      GCR_INTEG = 2'b10
   } gcr_state_t;

   // Initial accumulator value, -(16 x code) - 1, as a 15-bit signed word.
   function automatic logic [14:0] gcr_preload(input logic [7:0] pv);
      gcr_preload = ~{3'h0, pv, 4'h0};
   endfunction : gcr_preload

   // Cycles in one full step for a step time code.
   function automatic logic [23:0] gcr_step_cyc(input logic [3:0] code,
                                                input int unsigned us_cyc);
      gcr_step_cyc = 24'(int'(STEP_TIME_10US[code]) * 10 * us_cyc);
   endfunction : gcr_step_cyc

endpackage : gcr_pkg

// File: src/gcr_top.sv
// Serial command latch, gauge target registers and return-to-zero engine.
`timescale 1ns/100ps
module gcr_top #(
   parameter int unsigned US_CYCLES = gcr_pkg::CYC_PER_US  // Cycles per microsecond.
) (
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic        cs_b,
   input  wire logic        sclk,
   input  wire logic        mosi,
   input  wire logic        bemf_bit,
   output logic             miso_r,
   output logic             miso_oe_r,
   output logic [7:0]       vel0_r,
   output logic [7:0]       vel1_r,
   output logic [11:0]      pos0_r,
   output logic [11:0]      pos1_r,
   output logic             homing_busy_r,
   output logic             homing_gauge_r,
   output logic [1:0]       full_step_phase_r,
   output logic             full_step_pulse_r,
   output logic [1:0]       zero_found_r
);
   import gcr_pkg::*;

   //---------------------------------------------------------------------------
   // Pin synchronisers
   //---------------------------------------------------------------------------
   logic [3:0] meta_r;      // First stage, read only by the second.
   logic [3:0] sync_r;      // Second stage: {bemf, mosi, sclk, cs_b}.
   logic [1:0] prev_r;      // Delayed sclk and cs_b for edge detection.

   // Every pin passes two flops before any logic looks at it.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         meta_r <= 4'h1;
         sync_r <= 4'h1;
         prev_r <= 2'h3;
      end
      else
      begin
         meta_r <= {bemf_bit, mosi, sclk, cs_b};
         sync_r <= meta_r;
         prev_r <= sync_r[1:0];
      end
   end

   //---------------------------------------------------------------------------
   // Serial shifter
   //---------------------------------------------------------------------------
   logic [15:0] sh_r, sh_nxt;        // Shared in/out shift register.
   logic [3:0]  bits_r, bits_nxt;    // Bit count modulo sixteen.
   logic        any_r, any_nxt;      // At least one bit seen this frame.
   logic        latch_r, latch_nxt;  // One-cycle command strobe.
   gcr_cmd_t    cmd_r, cmd_nxt;      // Latched command word.
   logic        miso_nxt, oe_nxt;
   logic [15:0] status_w;            // Status word loaded at frame start.
   logic        cs_fall, cs_rise, sck_rise;

   assign cs_fall  = !sync_r[0] && prev_r[0];
   assign cs_rise  = sync_r[0] && !prev_r[0];
   assign sck_rise = sync_r[1] && !prev_r[1];

   // Received bits push the status out, so after sixteen clocks the first
   // received bit appears on the output, which lets devices daisy chain.
   always_comb
   begin
      sh_nxt    = sh_r;
      bits_nxt  = bits_r;
      any_nxt   = any_r;
      latch_nxt = 1'b0;
      cmd_nxt   = cmd_r;
      if (cs_fall)
      begin
         sh_nxt   = status_w;
         bits_nxt = 4'h0;
         any_nxt  = 1'b0;
      end
      else if (!sync_r[0] && sck_rise)
      begin
         sh_nxt   = {sh_r[14:0], sync_r[2]};
         bits_nxt = bits_r + 4'h1;
         any_nxt  = 1'b1;
      end
      else if (cs_rise && any_r && bits_r == 4'h0)
      begin
         latch_nxt = 1'b1;
         cmd_nxt   = sh_r;
      end
      miso_nxt = sh_nxt[15];
      oe_nxt   = !sync_r[0];
   end

   // Shifter registers.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         sh_r      <= 16'h0000;
         bits_r    <= 4'h0;
         any_r     <= 1'b0;
         latch_r   <= 1'b0;
         cmd_r     <= 16'h0000;
         miso_r    <= 1'b0;
         miso_oe_r <= 1'b0;
      end
      else
      begin
         sh_r      <= sh_nxt;
         bits_r    <= bits_nxt;
         any_r     <= any_nxt;
         latch_r   <= latch_nxt;
         cmd_r     <= cmd_nxt;
         miso_r    <= miso_nxt;
         miso_oe_r <= oe_nxt;
      end
   end

   //---------------------------------------------------------------------------
   // Command registers and homing engine
   //---------------------------------------------------------------------------
   gcr_state_t  st_r, st_nxt;           // Engine state.
   logic [23:0] cnt_r, cnt_nxt;         // Cycle within the current step.
   logic [14:0] acc_r, acc_nxt;         // Live accumulator.
   logic [14:0] res_r, res_nxt;         // Result of the previous step.
   logic [1:0]  flag_r, flag_nxt;       // Per-gauge homing status flags.
   logic [1:0]  done_r, done_nxt;       // Zero found, flag awaits a message.
   logic [1:0]  win_r, win_nxt;         // Readback window select.
   logic        unc_r, unc_nxt;         // Unconditional homing.
   logic [3:0]  code_r, code_nxt;       // Full step time code.
   logic        bsel_r, bsel_nxt;       // Blanking select.
   logic [7:0]  pv_r, pv_nxt;           // Accumulator preload code.
   logic [7:0]  vel0_nxt, vel1_nxt;
   logic [11:0] pos0_nxt, pos1_nxt;
   logic        busy_nxt, gsel_nxt, pulse_nxt;
   logic [1:0]  phase_nxt, zero_nxt;
   logic [7:0]  rdbk_w;                 // Accumulator window for status.
   logic [23:0] step_cyc, blank_cyc;
   logic        step_end;

   assign step_cyc  = gcr_step_cyc(code_r, US_CYCLES);
   assign blank_cyc = 24'((bsel_r ? BLANK_LONG_US : BLANK_SHORT_US) * US_CYCLES);
   assign step_end  = (st_r == GCR_INTEG) && (cnt_r == step_cyc - 24'h1);

   // The high window has only seven bits, so its top status bit reads zero.
   assign rdbk_w   = (win_r == 2'b00) ? res_r[7:0] :
                     (win_r == 2'b01) ? res_r[11:4] : {1'b0, res_r[14:8]};
   assign status_w = {rdbk_w, 4'h0, flag_r, 2'b00};

   // Next values: command decode first, then the engine, so that a stall
   // found in the same cycle as a message still marks its flag as finished.
   always_comb
   begin
      vel0_nxt  = vel0_r;
      vel1_nxt  = vel1_r;
      pos0_nxt  = pos0_r;
      pos1_nxt  = pos1_r;
      st_nxt    = st_r;
      cnt_nxt   = cnt_r;
      acc_nxt   = acc_r;
      res_nxt   = res_r;
      flag_nxt  = flag_r;
      done_nxt  = done_r;
      win_nxt   = win_r;
      unc_nxt   = unc_r;
      code_nxt  = code_r;
      bsel_nxt  = bsel_r;
      pv_nxt    = pv_r;
      gsel_nxt  = homing_gauge_r;
      phase_nxt = full_step_phase_r;
      pulse_nxt = 1'b0;
      zero_nxt  = 2'b00;
      if (latch_r)
      begin
         // A finished homing flag drops at the message after the zero.
         flag_nxt = flag_r & ~done_r;
         done_nxt = 2'b00;
      end
      // Ill-formed words fail every check and change nothing but the finished homing flags.
      if (!latch_r)
      begin
      end
      else if (cmd_r.addr == ADR_VEL)
      begin
         if (cmd_r.data[12:10] == 3'h0 && cmd_r.data[7:0] != 8'h00)
         begin
            if (cmd_r.data[8])
               vel0_nxt = cmd_r.data[7:0];
            if (cmd_r.data[9])
               vel1_nxt = cmd_r.data[7:0];
         end
      end
      else if (cmd_r.addr == ADR_POS0 || cmd_r.addr == ADR_POS1)
      begin
         if (!cmd_r.data[12])
         begin
            if (cmd_r.addr == ADR_POS0)
               pos0_nxt = cmd_r.data[11:0];
            else
               pos1_nxt = cmd_r.data[11:0];
         end
      end
      else if (cmd_r.addr == ADR_RTZ)
      begin
         if (cmd_r.data[12:5] == 8'h00)
         begin
            win_nxt = cmd_r.data[3:2];
            if (cmd_r.data[1] && st_r != GCR_IDLE && homing_gauge_r == cmd_r.data[0])
            begin
               // Same gauge already homing: keep stepping, so that a window
               // change neither restarts the step nor wipes the readback.
               unc_nxt = cmd_r.data[4];
            end
            else if (cmd_r.data[1])
            begin
               // One engine: a new enable takes it over for the named gauge.
               gsel_nxt = cmd_r.data[0];
               unc_nxt  = cmd_r.data[4];
               flag_nxt[cmd_r.data[0]] = 1'b1;
               done_nxt[cmd_r.data[0]] = 1'b0;
               st_nxt   = GCR_BLANK;
               cnt_nxt  = 24'h0;
               acc_nxt  = gcr_preload(pv_r);
               res_nxt  = ACC_FIRST;
            end
            else
            begin
               flag_nxt[cmd_r.data[0]] = 1'b0;
               if (st_r != GCR_IDLE && homing_gauge_r == cmd_r.data[0])
                  st_nxt = GCR_IDLE;
            end
         end
      end
      else if (cmd_r.addr == ADR_CFG)
      begin
         pv_nxt   = cmd_r.data[12:5];
         bsel_nxt = cmd_r.data[4];
         code_nxt = cmd_r.data[3:0];
      end
      // The engine runs only when no command redirected it this cycle.
      if (st_r != GCR_IDLE && st_nxt == st_r && cnt_nxt == cnt_r)
      begin
         cnt_nxt = cnt_r + 24'h1;
         if (st_r == GCR_BLANK && cnt_r >= blank_cyc - 24'h1)
            st_nxt = GCR_INTEG;
         if (st_r == GCR_INTEG)
         begin
            // Saturate rather than wrap so a long step cannot flip the sign.
            if (sync_r[3] && acc_r != ACC_MAX)
               acc_nxt = acc_r + 15'h1;
            else if (!sync_r[3] && acc_r != ACC_MIN)
               acc_nxt = acc_r - 15'h1;
         end
         if (step_end)
         begin
            res_nxt = acc_r;
            if (acc_r[14] && !unc_r)
            begin
               st_nxt = GCR_IDLE;
               done_nxt[homing_gauge_r] = 1'b1;
               zero_nxt[homing_gauge_r] = 1'b1;
            end
            else
            begin
               st_nxt    = GCR_BLANK;
               cnt_nxt   = 24'h0;
               acc_nxt   = gcr_preload(pv_r);
               phase_nxt = full_step_phase_r - 2'h1;
               pulse_nxt = 1'b1;
            end
         end
      end
      busy_nxt = (st_nxt != GCR_IDLE);
   end

   // Core registers.
   always_ff @(posedge sys_clk)
   begin
      if (!rst_b)
      begin
         vel0_r            <= VEL_RST;
         vel1_r            <= VEL_RST;
         pos0_r            <= POS_RST;
         pos1_r            <= POS_RST;
         st_r              <= GCR_IDLE;
         cnt_r             <= 24'h0;
         acc_r             <= ACC_ZERO;
         res_r             <= ACC_ZERO;
         flag_r            <= 2'b00;
         done_r            <= 2'b00;
         win_r             <= 2'b00;
         unc_r             <= 1'b0;
         code_r            <= STEP_CODE_RST;
         bsel_r            <= BLANK_SEL_RST;
         pv_r              <= PRELOAD_RST;
         homing_busy_r     <= 1'b0;
         homing_gauge_r    <= 1'b0;
         full_step_phase_r <= 2'b00;
         full_step_pulse_r <= 1'b0;
         zero_found_r      <= 2'b00;
      end
      else
      begin
         vel0_r            <= vel0_nxt;
         vel1_r            <= vel1_nxt;
         pos0_r            <= pos0_nxt;
         pos1_r            <= pos1_nxt;
         st_r              <= st_nxt;
         cnt_r             <= cnt_nxt;
         acc_r             <= acc_nxt;
         res_r             <= res_nxt;
         flag_r            <= flag_nxt;
         done_r            <= done_nxt;
         win_r             <= win_nxt;
         unc_r             <= unc_nxt;
         code_r            <= code_nxt;
         bsel_r            <= bsel_nxt;
         pv_r              <= pv_nxt;
         homing_busy_r     <= busy_nxt;
         homing_gauge_r    <= gsel_nxt;
         full_step_phase_r <= phase_nxt;
         full_step_pulse_r <= pulse_nxt;
         zero_found_r      <= zero_nxt;
      end
   end

   //---------------------------------------------------------------------------
   // Assertions
   //---------------------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);

   sequence s_step_end;
      step_end && !latch_r;
   endsequence

   sequence s_stall;
      s_step_end ##0 (acc_r[14] && !unc_r);
   endsequence

   a_vel_apply: assert property (latch_r && cmd_r.addr == ADR_VEL && cmd_r.data[12:10] == 3'h0
      && cmd_r.data[7:0] != 8'h00 |=> vel0_r == ($past(cmd_r.data[8]) ? $past(cmd_r.data[7:0])
      : $past(vel0_r))) else $error("gauge0 velocity wrong");
   a_pos_load: assert property (latch_r && cmd_r.addr == ADR_POS1 && !cmd_r.data[12]
      |=> pos1_r == $past(cmd_r.data[11:0])) else $error("gauge1 position not loaded");
   a_pos_reject: assert property (latch_r && cmd_r.addr == ADR_POS0 && cmd_r.data[12]
      |=> $stable(pos0_r)) else $error("invalid position accepted");
   a_first_read: assert property (latch_r && cmd_r.addr == ADR_RTZ && cmd_r.data[12:5] == 8'h00
      && cmd_r.data[1] && (st_r == GCR_IDLE || homing_gauge_r != cmd_r.data[0])
      |=> res_r == ACC_FIRST && st_r == GCR_BLANK) else $error("bad first read");
   a_window_live: assert property (latch_r && cmd_r.addr == ADR_RTZ && cmd_r.data[12:5] == 8'h00
      && cmd_r.data[1] && st_r != GCR_IDLE && homing_gauge_r == cmd_r.data[0] && !step_end
      |=> st_r != GCR_IDLE && cnt_r == $past(cnt_r) + 24'h1) else $error("window change broke step");
   a_sign_window: assert property (win_r[1] |-> status_w[14] == res_r[14] && !status_w[15])
      else $error("sign not on status 14");
   a_blank_wait: assert property (st_r == GCR_BLANK ##1 st_r == GCR_INTEG
      |-> cnt_r >= $past(blank_cyc)) else $error("integration inside blanking");
   a_step_preload: assert property (s_step_end ##0 !(acc_r[14] && !unc_r)
      |=> st_r == GCR_BLANK && cnt_r == 24'h0 && acc_r == gcr_preload(pv_r) && full_step_pulse_r)
      else $error("step not reinitialised");
   a_stall_stop: assert property (s_stall |=> st_r == GCR_IDLE
      ##0 zero_found_r[$past(homing_gauge_r)] ##1 !full_step_pulse_r[*3]) else $error("no stop");
   a_flag_hold: assert property (s_stall ##1 !latch_r |=> flag_r == $past(flag_r))
      else $error("homing flag dropped early");
   a_latch_len: assert property (latch_r |-> $past(cs_rise) && $past(any_r)
      && $past(bits_r) == 4'h0) else $error("latch on bad length");

endmodule : gcr_top

// File: test/gcr_host.sv
// Host model: serial master that frames command words and gathers status.
`timescale 1ns/100ps
module gcr_host (
   input  wire logic sys_clk,
   output logic      cs_b,
   output logic      sclk,
   output logic      mosi,
   input  wire logic miso_r,
   input  wire logic miso_oe_r
);
   //---------------------------------------------------------------------------
   // Frame timing
   //---------------------------------------------------------------------------
   // Half period of the serial clock in system clocks (200 ns).
   localparam int HALF = 10;

   // Idle: deselected, serial clock parked low between frames.
   initial
   begin
      cs_b = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end

   // One frame, MSB first, changed only on falling system edges.
   // A short frame drops the last bit so the word must be refused.
   // The caller keeps the must-be-zero fields clear in valid words.
   task automatic xfer(input logic [15:0] w, input bit short, output logic [15:0] rd);
      rd = 16'h0000;
      @(negedge sys_clk);
      cs_b = 1'b0;
      for (int i = 15; i >= (short ? 1 : 0); i--)
      begin
         mosi = w[i];
         repeat (HALF) @(negedge sys_clk);
         // Status is only trusted while the device drives its output.
         rd = {rd[14:0], (miso_oe_r === 1'b1) ? miso_r : 1'bx};
         sclk = 1'b1;
         repeat (HALF) @(negedge sys_clk);
         sclk = 1'b0;
      end
      repeat (HALF) @(negedge sys_clk);
      cs_b = 1'b1;
      // A released data line keeps no memory of the last bit.
      mosi = ~mosi;
      repeat (12) @(negedge sys_clk);
   endtask : xfer
endmodule : gcr_host

// File: test/tb_gcr_top.sv
// Testbench for the gauge command latch and return-to-zero engine.
`timescale 1ns/100ps
module tb_gcr_top;
   import gcr_pkg::*;

   //---------------------------------------------------------------------------
   // Signals
   //---------------------------------------------------------------------------
   logic        sys_clk = 1'b0, rst_b, cs_b, sclk, mosi, bemf_bit;  // Driven inputs.
   logic        miso_r, miso_oe_r, homing_busy_r, homing_gauge_r, full_step_pulse_r;
   logic [7:0]  vel0_r, vel1_r;                 // Velocity indices.
   logic [11:0] pos0_r, pos1_r;                 // Target positions.
   logic [1:0]  full_step_phase_r, zero_found_r; // Step phase and stall pulses.
   logic [15:0] s;                              // Last status word read.
   logic [1:0]  ph;                             // Phase before a step.
   int          err_count, n_tests, cyc, n;      // Counters.

   // Microsecond scaled to one cycle so a full step is thousands of cycles.
   gcr_top #(.US_CYCLES(1)) dut_u (
      .sys_clk(sys_clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk), .mosi(mosi),
      .bemf_bit(bemf_bit), .miso_r(miso_r), .miso_oe_r(miso_oe_r), .vel0_r(vel0_r),
      .vel1_r(vel1_r), .pos0_r(pos0_r), .pos1_r(pos1_r), .homing_busy_r(homing_busy_r),
      .homing_gauge_r(homing_gauge_r), .full_step_phase_r(full_step_phase_r),
      .full_step_pulse_r(full_step_pulse_r), .zero_found_r(zero_found_r));

   gcr_host host_u (.sys_clk(sys_clk), .cs_b(cs_b), .sclk(sclk), .mosi(mosi),
      .miso_r(miso_r), .miso_oe_r(miso_oe_r));

   //---------------------------------------------------------------------------
   // Clock and watchdog
   //---------------------------------------------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   // The whole run needs about 45000 cycles; twice that means a hang.
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         err_count++;
         conclude();
      end
   end

   //---------------------------------------------------------------------------
   // Helpers
   //---------------------------------------------------------------------------
   // Compare one value and count it.
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp)
      begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask : chk

   // Write one command word; the reply is not needed.
   task automatic wr(input logic [15:0] w, input bit short = 1'b0);
      logic [15:0] junk;
      host_u.xfer(w, short, junk);
   endtask : wr

   // Status read: a velocity word that applies to neither gauge only drops finished homing flags.
   task automatic st();
      host_u.xfer({ADR_VEL, 5'h00, 8'h01}, 1'b0, s);
   endtask : st

   // Wait for a step pulse or a gauge 0 stall pulse, with a bound.
   task automatic wev(input bit zf);
      n = 1;
      @(negedge sys_clk);
      while (((zf ? zero_found_r[0] : full_step_pulse_r) !== 1'b1) && n < 6000)
      begin
         @(negedge sys_clk);
         n++;
      end
      chk("event_seen", 16'h0001, 16'(n < 6000));
   endtask : wev

   // Single exit point with the verdict.
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : conclude

   //---------------------------------------------------------------------------
   // Main sequence
   //---------------------------------------------------------------------------
   initial
   begin
      err_count = 0;
      n_tests = 0;
      cyc = 0;
      rst_b = 1'b0;
      bemf_bit = 1'b0;
      repeat (12) @(negedge sys_clk);
      rst_b = 1'b1;
      repeat (4) @(negedge sys_clk);
      chk("vel0_rst", 16'h00ff, 16'(vel0_r));
      chk("busy_rst", 16'h0000, 16'(homing_busy_r));
      // Velocity apply bits pick the gauge; zero index and set D12 are refused.
      wr({ADR_VEL, 3'h0, 2'b01, 8'h12});
      chk("vel0", 16'h0012, 16'(vel0_r));
      chk("vel1", 16'h00ff, 16'(vel1_r));
      wr({ADR_VEL, 3'h0, 2'b10, 8'h01});
      chk("vel0_kept", 16'h0012, 16'(vel0_r));
      chk("vel1_new", 16'h0001, 16'(vel1_r));
      wr({ADR_VEL, 3'h0, 2'b01, 8'h00});
      wr({ADR_VEL, 3'h4, 2'b01, 8'h77});
      chk("vel0_refused", 16'h0012, 16'(vel0_r));
      // Positions at both ends of the range; bad words leave them alone.
      wr({ADR_POS0, 1'b0, 12'hfff});
      wr({ADR_POS1, 1'b0, 12'h000});
      wr({ADR_POS1, 1'b0, 12'ha5c});
      chk("pos0", 16'h0fff, 16'(pos0_r));
      chk("pos1", 16'h0a5c, 16'(pos1_r));
      wr({ADR_POS0, 1'b1, 12'h123});
      chk("pos0_d12", 16'h0fff, 16'(pos0_r));
      wr({ADR_POS1, 1'b0, 12'h111}, 1'b1);
      chk("pos1_short", 16'h0a5c, 16'(pos1_r));
      // Automatic homing on gauge 0 with a falling back-EMF: stall after one step.
      wr({ADR_CFG, 8'h00, 1'b0, 4'h0});
      wr({ADR_RTZ, 8'h00, 1'b0, 2'b10, 1'b1, 1'b0});
      chk("busy_g0", 16'h0001, 16'({homing_busy_r, homing_gauge_r} == 2'b10));
      st();
      chk("first_readback", 16'h007f, 16'(s[15:8]));
      chk("flag0_on", 16'h0001, 16'(s[2]));
      wev(1'b1);
      repeat (2) @(negedge sys_clk);
      chk("busy_stall", 16'h0000, 16'(homing_busy_r));
      st();
      chk("stall_window", 16'h006f, 16'(s[15:8]));
      chk("flag0_held", 16'h0001, 16'(s[2]));
      st();
      chk("flag0_off", 16'h0000, 16'(s[2]));
      // Gauge 1, rising back-EMF, deepest preload: keeps moving in full steps.
      bemf_bit = 1'b1;
      wr({ADR_CFG, 8'hff, 1'b0, 4'h0});
      wr({ADR_RTZ, 8'h00, 1'b0, 2'b01, 1'b1, 1'b1});
      wev(1'b0);
      ph = full_step_phase_r;
      wev(1'b0);
      chk("step_time", 16'h0001, 16'(n >= 4858 && n <= 4862));
      chk("phase", 16'(ph - 2'd1), 16'(full_step_phase_r));
      st();
      chk("readback_512", 16'h0010, 16'(s[15:8]));
      chk("flag1_on", 16'h0001, 16'(s[3] & homing_busy_r & homing_gauge_r));
      // Resending the enable with a new window must not restart the step.
      wr({ADR_RTZ, 8'h00, 1'b0, 2'b10, 1'b1, 1'b1});
      st();
      chk("window_live", 16'h0001, 16'(s[15:8]));
      // Longer blanking leaves less integration time in each step.
      wr({ADR_CFG, 8'hff, 1'b1, 4'h0});
      wev(1'b0);
      wev(1'b0);
      st();
      chk("readback_768", 16'h0000, 16'(s[15:8]));
      wr({ADR_RTZ, 8'h00, 1'b0, 2'b01, 1'b0, 1'b1});
      chk("busy_off", 16'h0000, 16'(homing_busy_r));
      // Unconditional homing ignores the stall sign until switched off.
      bemf_bit = 1'b0;
      wr({ADR_CFG, 8'h00, 1'b0, 4'h0});
      wr({ADR_RTZ, 8'h00, 1'b1, 2'b00, 1'b1, 1'b0});
      wev(1'b0);
      wev(1'b0);
      st();
      chk("readback_low", 16'h0004, 16'(s[15:8]));
      wr({ADR_RTZ, 8'h01, 1'b0, 2'b00, 1'b0, 1'b0});
      chk("uncond_run", 16'h0001, 16'(homing_busy_r));
      wr({ADR_RTZ, 8'h00, 1'b0, 2'b00, 1'b0, 1'b0});
      chk("uncond_stop", 16'h0000, 16'(homing_busy_r));
      conclude();
   end
endmodule : tb_gcr_top
